// *** swb_cfg.svh ***
// Register map, field positions, reset values and timing counts of the single-wire bus port
`ifndef SWB_CFG_SVH
`define SWB_CFG_SVH
// ****************************************
// Register indices, byte address is index times four
// ****************************************
`define SWB_IDX_DIV     8'hc0
`define SWB_IDX_CTRL    8'hc3
`define SWB_IDX_ST1     8'hc4
`define SWB_IDX_ST2     8'hc5
`define SWB_IDX_DATA    8'hc7
`define SWB_BYTE(idx)   {2'h0, idx, 2'b00}
// ****************************************
// Field positions
// ****************************************
`define SWB_CTRL_TXEN   3
`define SWB_CTRL_RXEN   2
`define SWB_ST1_FULL    5
`define SWB_ST1_BERR    3
`define SWB_ST1_NOISE   2
`define SWB_ST2_HALT    7
`define SWB_ST2_MODE    6
`define SWB_ST2_DHI     5
`define SWB_ST2_DLO     4
`define SWB_ST2_RXACT   0
// ****************************************
// Reset values
// ****************************************
`define SWB_CTRL_RST    1'b0
`define SWB_ST2_RST     1'b0
`define SWB_FLAG_RST    1'b0
`define SWB_LINE_RST    1'b1
`define SWB_DATA_RST    8'h00
// ****************************************
// Timing counts in sixteen-times ticks and bit slots
// ****************************************
`define SWB_SAMP_A      4'h7
`define SWB_SAMP_MID    4'h8
`define SWB_SAMP_B      4'h9
`define SWB_TICK_LAST   4'hf
`define SWB_PUSH_LAST   4'h7
`define SWB_PULL_LAST   4'h8
`endif

// *** swb_pkg.sv ***
// Types shared by the single-wire bus port
package swb_pkg;
	typedef enum logic [1:0] {
		SWB_IDLE = 2'b00,
		SWB_PUSH = 2'b01,
		SWB_WAIT = 2'b11,
		SWB_PULL = 2'b10
	} swb_state_t;
endpackage

// *** swb_serial.sv ***
// Single-wire bus mode of the serial port with its APB register slave
`timescale 1ns/1ns
`include "swb_cfg.svh"
// Function
// - Flag bit error when monitored push bit differs
// - Bit error never raises an interrupt request
// - Flag noise seen during pull field reception
// - Halt bit clock in wait when enabled
// - Enable bit selects single-wire bus behaviour
// - Two delay bits pick delay factor 1..4
// - Receiver active reads one while receiving
// - Data read returns status in bits 3..1
// - Valid frame shows fixed pattern around status
// - All ones byte means bus error
// - Pull bits LSB first, first maps bit 3
// - Push sends five data then three address
// - Data address splits into tx and rx registers
// - Bit rate is clock over sixteen divisor
// - Status read then data read clears flags
// - Reception starts on sync, blocked during push
// - Line monitored on receive pin while pushing
module swb_serial #(
	parameter int DIV_W = 13                    // Rate divisor width
) (
	input  wire logic        i_clock,          // 10 MHz module clock
	input  wire logic        i_rst_n,          // Synchronous reset
	input  wire logic        i_wait_mode,      // Processor in wait mode
	input  wire logic        i_serial_rx_pin,  // Bus line as seen
	output logic             o_serial_tx_pin,  // Bus drive, 0 is dominant
	input  wire logic        i_psel,           // APB select
	input  wire logic        i_penable,        // APB enable
	input  wire logic        i_pwrite,         // APB direction
	input  wire logic [11:0] i_paddr,          // APB byte address
	input  wire logic [31:0] i_pwdata,         // APB write data
	output logic [31:0]      o_prdata,         // APB read data
	output logic             o_pready,         // APB ready
	output logic             o_pslverr,        // APB error
	output swb_pkg::swb_state_t o_state        // Engine state
);
	import swb_pkg::*;

	generate
		if (DIV_W < 1 || DIV_W > 16) begin : g_bad_width
			$error("DIV_W must be 1 to 16");
		end
	endgenerate

	// ****************************************
	// APB decode
	// ****************************************
	logic             acc, wr, rd;
	logic             hit_div, hit_ctrl, hit_st1, hit_st2, hit_data, mapped;
	logic [DIV_W-1:0] div_r;
	logic             tx_en_r, rx_en_r, halt_r, mode_en_r;
	logic [1:0]       dsel_r;
	logic [7:0]       tx_data_r, rx_data_r, rx_sh_r;
	logic             full_r, berr_r, noise_r;
	logic [2:0]       snap_r;
	swb_state_t       state_r, state_nxt;
	logic [DIV_W-1:0] pre_r;
	logic [3:0]       tk_r, bit_r;
	logic [2:0]       dly_r;
	logic [1:0]       samp_r;
	logic             line_r;
	logic             s1_r, s2_r, s3_r, lvl_r;

	assign acc      = i_psel & i_penable;
	assign wr       = acc & i_pwrite;
	assign rd       = acc & ~i_pwrite;
	assign hit_div  = (i_paddr == `SWB_BYTE(`SWB_IDX_DIV));
	assign hit_ctrl = (i_paddr == `SWB_BYTE(`SWB_IDX_CTRL));
	assign hit_st1  = (i_paddr == `SWB_BYTE(`SWB_IDX_ST1));
	assign hit_st2  = (i_paddr == `SWB_BYTE(`SWB_IDX_ST2));
	assign hit_data = (i_paddr == `SWB_BYTE(`SWB_IDX_DATA));
	assign mapped   = hit_div | hit_ctrl | hit_st1 | hit_st2 | hit_data;
	assign o_pready  = 1'b1;
	assign o_pslverr = acc & ~mapped;

	// ****************************************
	// Read mux
	// ****************************************
	logic [7:0] st1_val, st2_val, ctrl_val;
	logic       rx_act;

	assign rx_act   = (state_r == SWB_PULL);
	assign ctrl_val = {4'h0, tx_en_r, rx_en_r, 2'b00};
	assign st1_val  = {2'b00, full_r, 1'b0, berr_r, noise_r, 2'b00};
	assign st2_val  = {halt_r, mode_en_r, dsel_r, 3'b000, rx_act};
	// Data reads see only the receive register, never the transmit one
	assign o_prdata = hit_div  ? {{(32-DIV_W){1'b0}}, div_r} :
	                  hit_ctrl ? {24'h0, ctrl_val} :
	                  hit_st1  ? {24'h0, st1_val} :
	                  hit_st2  ? {24'h0, st2_val} :
	                  hit_data ? {24'h0, rx_data_r} : 32'h0;

	// ****************************************
	// Rate generator
	// ****************************************
	logic tick, gen_on;

	assign gen_on = (div_r != '0) & ~(halt_r & i_wait_mode);
	assign tick   = gen_on & (pre_r == div_r - 1'b1);

	always_ff @(posedge i_clock) begin
		if (!i_rst_n || !gen_on || tick) begin
			pre_r <= '0;
		end else begin
			pre_r <= pre_r + 1'b1;
		end
	end

	// ****************************************
	// Receive pin synchroniser
	// ****************************************
	logic rx_fall;

	// The level moves only once the second and third stages agree
	assign rx_fall = lvl_r & ~s2_r & ~s3_r;

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			s1_r  <= 1'b1;
			s2_r  <= 1'b1;
			s3_r  <= 1'b1;
			lvl_r <= 1'b1;
		end else begin
			s1_r <= i_serial_rx_pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				lvl_r <= s3_r;
			end
		end
	end

	// ****************************************
	// Engine events
	// ****************************************
	logic push_go, push_cmp, push_end, push_done, berr_ev;
	logic pull_sync, counting, pull_tick, maj, noise_ev, pull_done;
	logic idle_like;
	logic [7:0] rx_map;

	assign idle_like = (state_r == SWB_IDLE) | (state_r == SWB_WAIT);
	// A write while a field is on the wire is dropped
	assign push_go   = wr & hit_data & mode_en_r & tx_en_r & idle_like;
	assign push_cmp  = (state_r == SWB_PUSH) & tick & (tk_r == `SWB_SAMP_MID);
	assign push_end  = (state_r == SWB_PUSH) & tick & (tk_r == `SWB_TICK_LAST);
	assign push_done = push_end & (bit_r == `SWB_PUSH_LAST);
	assign berr_ev   = push_cmp & (lvl_r != line_r);
	// Sync is looked for only while waiting, so a push field never starts one
	assign pull_sync = (state_r == SWB_WAIT) & rx_en_r & rx_fall & ~push_go;
	assign counting  = (dly_r == 3'h0);
	assign pull_tick = (state_r == SWB_PULL) & tick & counting;
	assign maj       = (samp_r[0] & samp_r[1]) | (samp_r[0] & lvl_r) | (samp_r[1] & lvl_r);
	assign noise_ev  = pull_tick & (tk_r == `SWB_SAMP_B) &
	                   ~((samp_r[0] == samp_r[1]) & (samp_r[1] == lvl_r));
	assign pull_done = pull_tick & (tk_r == `SWB_TICK_LAST) & (bit_r == `SWB_PULL_LAST);
	// First status bit shifts into position 1, so it is swapped to position 3
	assign rx_map    = {rx_sh_r[7:4], rx_sh_r[1], rx_sh_r[2], rx_sh_r[3], rx_sh_r[0]};

	// ****************************************
	// State machine
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SWB_IDLE: begin
				if (push_go) begin
					state_nxt = SWB_PUSH;
				end else if (mode_en_r && rx_en_r) begin
					state_nxt = SWB_WAIT;
				end
			end
			SWB_PUSH: begin
				if (!mode_en_r) begin
					state_nxt = SWB_IDLE;
				end else if (push_done) begin
					state_nxt = rx_en_r ? SWB_WAIT : SWB_IDLE;
				end
			end
			SWB_WAIT: begin
				if (push_go) begin
					state_nxt = SWB_PUSH;
				end else if (!mode_en_r || !rx_en_r) begin
					state_nxt = SWB_IDLE;
				end else if (pull_sync) begin
					state_nxt = SWB_PULL;
				end
			end
			SWB_PULL: begin
				if (!mode_en_r) begin
					state_nxt = SWB_IDLE;
				end else if (pull_done) begin
					state_nxt = SWB_WAIT;
				end
			end
			default: begin
				state_nxt = SWB_IDLE;
			end
		endcase
	end

	assign o_state = state_r;

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			state_r <= SWB_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ****************************************
	// Slot counters and receive delay
	// ****************************************
	logic slot_step;

	assign slot_step = ((state_r == SWB_PUSH) & tick) | pull_tick;

	always_ff @(posedge i_clock) begin
		if (!i_rst_n || state_nxt != state_r) begin
			tk_r  <= 4'h0;
			bit_r <= 4'h0;
		end else if (slot_step) begin
			tk_r <= tk_r + 1'b1;
			if (tk_r == `SWB_TICK_LAST) begin
				bit_r <= bit_r + 1'b1;
			end
		end
	end

	// Delay factor is code plus one, each unit one tick or a sixteenth slot
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			dly_r <= 3'h0;
		end else if (pull_sync) begin
			dly_r <= {1'b0, dsel_r} + 3'h1;
		end else if ((state_r == SWB_PULL) && tick && !counting) begin
			dly_r <= dly_r - 3'h1;
		end
	end

	// ****************************************
	// Push shifter, data bits leave first
	// ****************************************
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			line_r    <= `SWB_LINE_RST;
			tx_data_r <= `SWB_DATA_RST;
		end else if (push_go) begin
			tx_data_r <= i_pwdata[7:0];
			line_r    <= i_pwdata[0];
		end else if (push_end && !push_done) begin
			line_r <= tx_data_r[3'(bit_r + 4'h1)];
		end else if (state_r != SWB_PUSH || push_done) begin
			line_r <= 1'b1;
		end
	end

	assign o_serial_tx_pin = line_r;

	// ****************************************
	// Pull receiver, three samples per slot
	// ****************************************
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			samp_r    <= 2'b11;
			rx_sh_r   <= `SWB_DATA_RST;
			rx_data_r <= `SWB_DATA_RST;
		end else begin
			if (pull_tick && tk_r == `SWB_SAMP_A) begin
				samp_r[0] <= lvl_r;
			end
			if (pull_tick && tk_r == `SWB_SAMP_MID) begin
				samp_r[1] <= lvl_r;
			end
			// Slot 0 is the sync slot and carries no data
			if (pull_tick && tk_r == `SWB_SAMP_B && bit_r != 4'h0) begin
				rx_sh_r <= {maj, rx_sh_r[7:1]};
			end
			// Pattern and all-ones error byte pass through unaltered
			if (pull_done) begin
				rx_data_r <= rx_map;
			end
		end
	end

	// ****************************************
	// Registers and flags
	// ****************************************
	logic [2:0] clr;

	// Only flags seen by the status read are cleared by the data read
	assign clr = (rd & hit_data) ? snap_r : 3'b000;

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			div_r     <= '0;
			tx_en_r   <= `SWB_CTRL_RST;
			rx_en_r   <= `SWB_CTRL_RST;
			halt_r    <= `SWB_ST2_RST;
			mode_en_r <= `SWB_ST2_RST;
			dsel_r    <= {2{`SWB_ST2_RST}};
		end else if (wr) begin
			if (hit_div) begin
				div_r <= i_pwdata[DIV_W-1:0];
			end
			if (hit_ctrl) begin
				tx_en_r <= i_pwdata[`SWB_CTRL_TXEN];
				rx_en_r <= i_pwdata[`SWB_CTRL_RXEN];
			end
			if (hit_st2) begin
				halt_r    <= i_pwdata[`SWB_ST2_HALT];
				mode_en_r <= i_pwdata[`SWB_ST2_MODE];
				dsel_r    <= {i_pwdata[`SWB_ST2_DHI], i_pwdata[`SWB_ST2_DLO]};
			end
		end
	end

	// A flag set in the clearing cycle survives; no interrupt output exists
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			full_r  <= `SWB_FLAG_RST;
			berr_r  <= `SWB_FLAG_RST;
			noise_r <= `SWB_FLAG_RST;
			snap_r  <= 3'b000;
		end else begin
			full_r  <= pull_done | (full_r & ~clr[2]);
			berr_r  <= berr_ev | (berr_r & ~clr[1]);
			noise_r <= noise_ev | (noise_r & ~clr[0]);
			if (rd && hit_st1) begin
				snap_r <= {full_r, berr_r, noise_r};
			end else if (rd && hit_data) begin
				snap_r <= 3'b000;
			end
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	a_bit_err_set: assert property (berr_ev |=> berr_r)
		else $error("bit error not flagged");
	a_noise_set: assert property (noise_ev |=> noise_r)
		else $error("noise not flagged");
	a_wait_halt: assert property (halt_r && i_wait_mode |-> !tick)
		else $error("tick while halted in wait");
	a_mode_off: assert property (!mode_en_r ##1 !mode_en_r |=> state_r == SWB_IDLE && line_r)
		else $error("engine active with mode off");
	a_rx_delay: assert property (pull_sync |=> dly_r == {1'b0, $past(dsel_r)} + 3'h1)
		else $error("wrong receive delay");
	a_rx_active: assert property (pull_sync |=> st2_val[0] ##1 $past(st2_val[0]))
		else $error("receiver active not shown");
	a_status_map: assert property (pull_done |=> rx_data_r[3] == $past(rx_sh_r[1]))
		else $error("status bit order wrong");
	a_push_first: assert property (push_go |=> line_r == $past(i_pwdata[0]))
		else $error("push does not start with bit 0");
	a_flag_clear: assert property (rd && hit_data && snap_r[1] && !berr_ev |=> !berr_r)
		else $error("flag survived clear sequence");
	a_div_off: assert property (div_r == '0 |-> !tick ##1 pre_r == '0)
		else $error("generator runs with zero divisor");
	a_push_block: assert property (state_r == SWB_PUSH |-> !pull_sync && !rx_act)
		else $error("reception during push");

	c_push_done: cover property (push_done);
	c_pull_done: cover property (pull_done);
	c_bit_error: cover property (berr_ev);
	c_noise: cover property (noise_ev);
endmodule

// *** swb_slave_model.sv ***
// Slave model for the single-wire bus: wired line and pull frames on command
`timescale 1ns/1ns
module swb_slave_model (
	input  wire logic       i_clock,  // Module clock
	input  wire logic       i_rst_n,  // Synchronous reset, active low
	input  wire logic       i_tx_pin, // Device drive, 0 dominant
	input  wire logic       i_send,   // Start one pull frame
	input  wire logic [7:0] i_byte,   // Frame bits, LSB first
	input  wire logic [3:0] i_glitch, // Two-cycle glitch offset in slot 4, 0 none
	input  wire logic       i_break,  // Hold the line dominant
	output logic            o_line    // Line level seen by everyone
);
	logic [3:0] cnt_r;
	logic [3:0] slot_r;
	logic       busy_r;
	logic       drv;
	logic       glt;
	// Slot 0 is the low sync slot, slots 1..8 carry the byte
	assign drv = !busy_r || (slot_r != 4'h0 && i_byte[slot_r[2:0] - 3'h1]);
	assign glt = busy_r && slot_r == 4'h4 && i_glitch != 4'h0
		&& (cnt_r == i_glitch || cnt_r == i_glitch + 4'h1);
	// Released line goes to the pull-up level; any party pulls it low
	assign o_line = i_tx_pin & (drv ^ glt) & !i_break;
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			busy_r <= 1'b0;
			cnt_r  <= 4'h0;
			slot_r <= 4'h0;
		end else if (!busy_r) begin
			busy_r <= i_send;
			cnt_r  <= 4'h0;
			slot_r <= 4'h0;
		end else begin
			cnt_r <= cnt_r + 4'h1;
			if (cnt_r == 4'hf) begin
				slot_r <= slot_r + 4'h1;
				busy_r <= slot_r != 4'h8;
			end
		end
	end
endmodule

// *** swb_serial_bench.sv ***
// Self-checking bench of the single-wire bus port against a slave model
`timescale 1ns/1ns
`include "swb_cfg.svh"
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED t=%0t %s", $time, m); end end
module swb_serial_bench;
	import swb_pkg::*;
	localparam logic [11:0] A_DIV  = `SWB_BYTE(`SWB_IDX_DIV);
	localparam logic [11:0] A_CTRL = `SWB_BYTE(`SWB_IDX_CTRL);
	localparam logic [11:0] A_ST1  = `SWB_BYTE(`SWB_IDX_ST1);
	localparam logic [11:0] A_ST2  = `SWB_BYTE(`SWB_IDX_ST2);
	localparam logic [11:0] A_DATA = `SWB_BYTE(`SWB_IDX_DATA);
	localparam logic [11:0] AMAP [0:4] = '{A_DIV, A_CTRL, A_ST1, A_ST2, A_DATA};
	logic        clock;
	logic        rst_n;
	logic        wait_mode;
	logic        line;
	logic        tx;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	swb_state_t  state;
	logic        send;
	logic [7:0]  sbyte;
	logic [3:0]  glitch;
	logic        brk;
	int          n_errors;
	int          checks;
	int          cycles;
	swb_serial #(.DIV_W(13)) uut (.i_clock(clock), .i_rst_n(rst_n), .i_wait_mode(wait_mode),
		.i_serial_rx_pin(line), .o_serial_tx_pin(tx), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .o_state(state));
	swb_slave_model slave (.i_clock(clock), .i_rst_n(rst_n), .i_tx_pin(tx), .i_send(send),
		.i_byte(sbyte), .i_glitch(glitch), .i_break(brk), .o_line(line));
	// ****************************************
	// Bus cycles
	// ****************************************
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		// Only the bench timeout ends a wait that never sees ready
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
	endtask
	// Bit k is looked at in mid slot, len cycles per slot
	task automatic push_check(input logic [7:0] b, input int len);
		wr(A_DATA, {24'h0, b});
		repeat (len / 2) @(negedge clock);
		for (int k = 0; k < 8; k++) begin
			`CHK(tx, b[k], "push bit order")
			repeat (len) @(negedge clock);
		end
		`CHK(tx, 1'b1, "pin released after push")
		`CHK(state, SWB_WAIT, "waiting for pull after push")
		@(posedge clock);
	endtask
	task automatic pull(input logic [7:0] b, input logic [3:0] g);
		logic [31:0] r;
		int          n;
		sbyte  <= b;
		glitch <= g;
		send   <= 1'b1;
		@(posedge clock);
		send <= 1'b0;
		n = 0;
		while (state !== SWB_PULL && n < 40) begin
			@(posedge clock);
			n++;
		end
		rd(A_ST2, r);
		`CHK(r[`SWB_ST2_RXACT], 1'b1, "receiver active in pull")
		n = 0;
		while (state !== SWB_WAIT && n < 300) begin
			@(posedge clock);
			n++;
		end
		rd(A_ST2, r);
		`CHK(r[`SWB_ST2_RXACT], 1'b0, "receiver idle after pull")
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		logic [31:0] r;
		logic        e;
		`CHK(tx, 1'b1, "idle pin")
		`CHK(pready, 1'b1, "no wait states")
		for (int i = 0; i < 5; i++) begin
			rd(AMAP[i], r);
			`CHK(r, 32'h0, "reset value")
		end
		apb(1'b1, 12'h004, 32'hff, r, e);
		`CHK(e, 1'b1, "unmapped write refused")
		apb(1'b0, 12'h004, 32'h0, r, e);
		`CHK({e, r}, 33'h100000000, "unmapped read")
	endtask
	task automatic t_mode_off();
		logic [31:0] r;
		wr(A_DIV, 32'h1);
		wr(A_CTRL, 32'hc);
		wr(A_DATA, 32'ha5);
		repeat (20) @(negedge clock);
		`CHK(tx, 1'b1, "no push with mode off")
		`CHK(state, SWB_IDLE, "idle with mode off")
		@(posedge clock);
		rd(A_DATA, r);
		`CHK(r, 32'h0, "data read gives receive side")
	endtask
	task automatic t_push();
		logic [31:0] r;
		wait_mode <= 1'b1;
		wr(A_ST2, 32'h71);
		rd(A_ST2, r);
		`CHK(r, 32'h70, "status two control bits")
		wr(A_ST2, 32'h40);
		push_check(8'ha6, 16);
		wait_mode <= 1'b0;
		rd(A_ST1, r);
		`CHK(r, 32'h0, "clean push leaves flags clear")
		wr(A_DIV, 32'h2);
		push_check(8'h5a, 32);
		wr(A_DIV, 32'h1);
	endtask
	task automatic t_bit_error();
		logic [31:0] r;
		brk <= 1'b1;
		wr(A_DATA, 32'hff);
		repeat (100) @(posedge clock);
		brk <= 1'b0;
		repeat (40) @(posedge clock);
		rd(A_ST1, r);
		`CHK(r[`SWB_ST1_BERR], 1'b1, "bit error flagged")
		rd(A_DATA, r);
		rd(A_ST1, r);
		`CHK(r, 32'h0, "flags cleared by read pair")
	endtask
	task automatic t_freeze(input logic use_div);
		if (use_div) begin
			wr(A_DIV, 32'h0);
		end else begin
			wr(A_ST2, 32'hc0);
			wait_mode <= 1'b1;
		end
		wr(A_DATA, 32'h02);
		// Bit 1 is high, so a running bit clock would show a one here
		repeat (24) @(negedge clock);
		`CHK(tx, 1'b0, "bit clock held")
		@(posedge clock);
		wait_mode <= 1'b0;
		wr(A_DIV, 32'h1);
		wr(A_ST2, 32'h40);
		repeat (160) @(negedge clock);
		`CHK(state, SWB_WAIT, "push resumes")
		@(posedge clock);
	endtask
	task automatic t_pulls();
		logic [31:0] r;
		logic [2:0]  s;
		logic [2:0]  st [0:3] = '{3'b100, 3'b011, 3'b001, 3'b110};
		for (int c = 0; c < 4; c++) begin
			s = st[c];
			wr(A_ST2, 32'h40 | (32'(c) << 4));
			pull({4'b0101, s[0], s[1], s[2], 1'b1}, 4'h0);
			rd(A_ST1, r);
			`CHK(r, 32'h20, "full without noise")
			rd(A_DATA, r);
			`CHK(r, {24'h0, 4'b0101, s, 1'b1}, "pull status")
		end
		rd(A_ST1, r);
		`CHK(r, 32'h0, "full cleared")
		pull(8'hff, 4'h0);
		rd(A_ST1, r);
		rd(A_DATA, r);
		`CHK(r, 32'hff, "all ones kept")
		// A glitch at offset 12 of slot 4 meets the samples only with the two longest delays
		wr(A_ST2, 32'h40);
		pull(8'h5b, 4'hc);
		rd(A_ST1, r);
		`CHK(r[`SWB_ST1_NOISE], 1'b0, "glitch missed with shortest delay")
		rd(A_DATA, r);
		wr(A_ST2, 32'h70);
		pull(8'h5b, 4'hc);
		rd(A_ST1, r);
		`CHK(r[`SWB_ST1_NOISE], 1'b1, "glitch caught with longest delay")
		rd(A_DATA, r);
		for (int g = 2; g < 12; g += 2) begin
			pull(8'h5b, 4'(g));
		end
		rd(A_ST1, r);
		`CHK(r[`SWB_ST1_NOISE], 1'b1, "noise flagged")
	endtask
	task automatic finish_test();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// Ceiling is about ten times the expected run of about 3000 cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 30000) begin
			n_errors++;
			finish_test();
		end
	end
	initial begin
		{rst_n, wait_mode, psel, penable, pwrite, send, brk} = 7'h0;
		{paddr, pwdata, sbyte, glitch} = 56'h0;
		{n_errors, checks, cycles} = {32'h0, 32'h0, 32'h0};
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		t_reset();
		t_mode_off();
		t_push();
		t_bit_error();
		t_freeze(1'b1);
		t_freeze(1'b0);
		t_pulls();
		finish_test();
	end
endmodule
